// File: hw/nvclk_host.sv
`timescale 1ns/1ns
// Operation
// - Clock bytes use the very same bus cycles as any location.
// - Host holds location lines stable through every write cycle.
// - Host returns a select or strobe inactive for recovery between cycles.
// - Host sets write data before write end and holds it afterward.
// - Host keeps read drive enable high during write cycles.
module nvclk_host
	import nvclk_host_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [1:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic [12:0]      location_lines,
	output logic             select_n_a,
	output logic             select_b,
	output logic             read_drive_n,
	output logic             store_n,
	input  wire logic [7:0]  byte_pins_in,
	output logic      [7:0]  byte_pins_out,
	output logic             byte_pins_oe,
	input  wire logic        supply_good,
	input  wire logic        below_backup
);

	host_state_t       state_r;
	logic [CNT_W-1:0]  cnt_r;
	logic [12:0]       loc_r;
	logic              is_write_r;
	logic [7:0]        wdata_r;
	logic [7:0]        rdata_r;
	logic              refused_r;
	logic              ack_r;
	logic [1:0]        pwr_sync;
	logic              go_cmd;

	// Supply levels arrive from outside the clock domain.
	pin_sync2 #(.WIDTH(2)) u_pwr_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({below_backup, supply_good}),
		.sync_out (pwr_sync)
	);

	// Clock window test, used by status and by the clock-write cover.
	function automatic logic in_clock_window(input logic [12:0] loc);
		return loc >= CLOCK_BASE_LOC && loc <= CLOCK_TOP_LOC;
	endfunction

	assign go_cmd = avs_write && avs_address == REG_CMD && state_r == ST_IDLE
		&& !ack_r && avs_writedata[CMD_GO_BIT];

	// Sequencer; clock bytes take the same path as any location.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (go_cmd && pwr_sync[0]) begin
						state_r <= avs_writedata[CMD_WRITE_BIT] ? ST_WRITE_DRIVE : ST_READ;
						cnt_r   <= avs_writedata[CMD_WRITE_BIT]
							? CNT_W'(HIZ_CYC) : CNT_W'(READ_CYC);
					end
				end
				ST_READ, ST_WRITE_DRIVE, ST_WRITE_PULSE, ST_HOLD, ST_RECOVER: begin
					if (cnt_r > CNT_W'(1)) begin
						cnt_r <= cnt_r - CNT_W'(1);
					end else begin
						unique case (state_r)
							ST_READ: begin
								state_r <= ST_RECOVER;
								cnt_r   <= CNT_W'(RECOV_CYC);
							end
							ST_WRITE_DRIVE: begin
								state_r <= ST_WRITE_PULSE;
								cnt_r   <= CNT_W'(WPULSE_CYC > DSETUP_CYC
									? WPULSE_CYC : DSETUP_CYC);
							end
							ST_WRITE_PULSE: begin
								state_r <= ST_HOLD;
								cnt_r   <= CNT_W'(DHOLD_CYC);
							end
							ST_HOLD: begin
								state_r <= ST_RECOVER;
								cnt_r   <= CNT_W'(RECOV_CYC);
							end
							default: begin
								state_r <= ST_IDLE;
								cnt_r   <= '0;
							end
						endcase
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Command capture; location held constant for the whole cycle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			loc_r      <= '0;
			is_write_r <= 1'b0;
			wdata_r    <= '0;
			refused_r  <= 1'b0;
		end else begin
			if (avs_write && avs_address == REG_WDATA && state_r == ST_IDLE && !ack_r) begin
				wdata_r <= avs_writedata[7:0];
			end
			if (go_cmd) begin
				loc_r      <= avs_writedata[CMD_LOC_LSB +: LOC_W];
				is_write_r <= avs_writedata[CMD_WRITE_BIT];
				refused_r  <= !pwr_sync[0];
			end
		end
	end

	// Pin drive: read enable stays high in writes, data driven only in writes.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			location_lines <= '0;
			select_n_a     <= 1'b1;
			select_b       <= 1'b0;
			read_drive_n   <= 1'b1;
			store_n        <= 1'b1;
			byte_pins_out  <= '0;
			byte_pins_oe   <= 1'b0;
		end else begin
			location_lines <= loc_r;
			select_n_a     <= !(state_r inside {ST_READ, ST_WRITE_DRIVE, ST_WRITE_PULSE});
			select_b       <= state_r inside {ST_READ, ST_WRITE_DRIVE, ST_WRITE_PULSE};
			read_drive_n   <= state_r != ST_READ;
			store_n        <= state_r != ST_WRITE_PULSE;
			byte_pins_out  <= wdata_r;
			byte_pins_oe   <= state_r inside {ST_WRITE_PULSE, ST_HOLD};
		end
	end

	// Read data is taken at the edge that ends the select window. The pins turn active one
	// cycle after the state does, so sampling in the last read cycle would fall one cycle
	// short of the access time; the first recovery cycle still sees the pins active.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_r <= '0;
		end else if (state_r == ST_RECOVER && cnt_r == CNT_W'(RECOV_CYC) && !is_write_r) begin
			rdata_r <= byte_pins_in;
		end
	end

	// Avalon slave: one wait cycle, then acknowledge; busy is refused.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_r           <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
		end else begin
			ack_r           <= (avs_read || avs_write) && !ack_r;
			avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
			if (avs_read && !ack_r) begin
				unique case (avs_address)
					REG_CMD:    avs_readdata <= {19'h0, loc_r};
					REG_WDATA:  avs_readdata <= {24'h0, wdata_r};
					REG_STATUS: avs_readdata <= {27'h0, refused_r,
						in_clock_window(loc_r), pwr_sync[1], !pwr_sync[0],
						state_r != ST_IDLE};
					REG_RDATA:  avs_readdata <= {24'h0, rdata_r};
					default:    avs_readdata <= BAD_ADDR_DATA;
				endcase
			end
		end
	end

	// Assertions.
	property p_read_pins;
		@(posedge clk_sys) disable iff (rst)
		!read_drive_n |-> (!select_n_a && select_b && store_n && !byte_pins_oe);
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("read drive outside read");

	property p_loc_stable;
		@(posedge clk_sys) disable iff (rst)
		!store_n |-> $stable(location_lines);
	endproperty
	a_loc_stable: assert property (p_loc_stable) else $error("location moved in write");

	property p_data_hold;
		@(posedge clk_sys) disable iff (rst)
		$rose(store_n) |-> byte_pins_oe && $stable(byte_pins_out);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("write data not held");

	property p_pulse_len;
		@(posedge clk_sys) disable iff (rst)
		$fell(store_n) |-> !store_n [*8];
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("write pulse too short");

	property p_recover;
		@(posedge clk_sys) disable iff (rst)
		$rose(select_n_a) |-> select_n_a [*2];
	endproperty
	a_recover: assert property (p_recover) else $error("recovery too short");

	property p_no_cycle_unpowered;
		@(posedge clk_sys) disable iff (rst)
		(state_r == ST_IDLE && !pwr_sync[0]) |=> state_r == ST_IDLE;
	endproperty
	a_no_cycle_unpowered: assert property (p_no_cycle_unpowered) else $error("cycle w/o supply");

	property p_read_len;
		@(posedge clk_sys) disable iff (rst)
		$fell(read_drive_n) |-> !read_drive_n [*8];
	endproperty
	a_read_len: assert property (p_read_len) else $error("read window short");

	property p_wait_one;
		@(posedge clk_sys) disable iff (rst)
		(avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("slave did not answer");

	c_read:  cover property (@(posedge clk_sys) disable iff (rst) $rose(read_drive_n));
	c_write: cover property (@(posedge clk_sys) disable iff (rst) $rose(store_n));
	c_clock: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(store_n) && in_clock_window(location_lines));

endmodule

// File: pkg/nvclk_host_pkg.sv
package nvclk_host_pkg;

	// Device side: byte array and clock window.
	localparam int          LOC_W           = 13;
	localparam int          DATA_W          = 8;
	localparam logic [12:0] CLOCK_BASE_LOC  = 13'h1ff8;
	localparam logic [12:0] CLOCK_TOP_LOC   = 13'h1fff;
	localparam logic [12:0] CLOCK_CTRL_LOC  = 13'h1ff8;

	// Own register map on the Avalon-MM side (word addresses).
	localparam logic [1:0] REG_CMD         = 2'h0;
	localparam logic [1:0] REG_WDATA       = 2'h1;
	localparam logic [1:0] REG_STATUS      = 2'h2;
	localparam logic [1:0] REG_RDATA       = 2'h3;
	localparam int         CMD_LOC_LSB     = 0;
	localparam int         CMD_WRITE_BIT   = 16;
	localparam int         CMD_GO_BIT      = 31;
	localparam int         STAT_BUSY_BIT   = 0;
	localparam int         STAT_PROT_BIT   = 1;
	localparam int         STAT_BATT_BIT   = 2;
	localparam int         STAT_CLOCK_BIT  = 3;
	localparam int         STAT_REFUSE_BIT = 4;
	localparam logic [31:0] BAD_ADDR_DATA  = 32'hdeadbeef;

	// Pin timing in nanoseconds, and derived 4 ns cycle counts.
	localparam int CLK_NS       = 4;
	localparam int T_READ_NS    = 70;
	localparam int T_WPULSE_NS  = 55;
	localparam int T_DSETUP_NS  = 30;
	localparam int T_DHOLD_NS   = 5;
	localparam int T_RECOV_NS   = 5;
	localparam int T_HIZ_NS     = 25;
	localparam int READ_CYC     = (T_READ_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPULSE_CYC   = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int DSETUP_CYC   = (T_DSETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int DHOLD_CYC    = (T_DHOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOV_CYC    = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
	localparam int HIZ_CYC      = (T_HIZ_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W        = 6;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE_DRIVE,
		ST_WRITE_PULSE,
		ST_HOLD,
		ST_RECOVER
	} host_state_t;

endpackage

// File: hw/pin_sync2.sv
`timescale 1ns/1ns
// Two-stage synchroniser for a bus of asynchronous pin levels.
module pin_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// The first stage feeds the second stage only.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// File: verif/nvclk_dev_model.sv
`timescale 1ns/1ns
// Behavioural byte-wide memory with the clock window; it reacts to pin levels only.
module nvclk_dev_model
	import nvclk_host_pkg::*;
#(
	// Length of one clock second; the bench shortens it so that a refresh falls in the run.
	parameter int TICK_NS = 1000000000
) (
	input  wire logic [12:0] location_lines,
	input  wire logic        select_n_a,
	input  wire logic        select_b,
	input  wire logic        read_drive_n,
	input  wire logic        store_n,
	input  wire logic [7:0]  bus_in,
	output logic      [7:0]  dev_q,
	output logic             dev_oe,
	input  wire logic        supply_good,
	input  wire logic        below_backup
);
	// Clock bytes 1ff8..1fff are plain cells here, reached like any other byte.
	logic [7:0]  mem [0:8191];
	logic [7:0]  last_q = 8'h00;
	logic        sel;
	logic        wr_mode;
	logic        sel_d;
	logic [12:0] loc_d;
	// Power-fail deselect masks every pin; battery mode only keeps the array.
	assign sel     = !select_n_a && select_b && supply_good;
	assign wr_mode = sel && !store_n;
	assign dev_oe  = sel && store_n && !read_drive_n;
	// Inertial delays model the access times, so an early sample sees junk.
	assign #70 sel_d = sel;
	assign #70 loc_d = location_lines;
	// A released bus shows the inverse of the last value, never a lucky match.
	assign dev_q = (dev_oe && sel_d && loc_d === location_lines) ? mem[location_lines] : ~last_q;
	always @(negedge dev_oe) begin
		last_q = mem[location_lines];
	end
	// Data is captured at whichever control ends the write first.
	always @(negedge wr_mode) begin
		if (supply_good) begin
			mem[location_lines] = bus_in;
		end
	end
	// Free-running counters behind the clock bytes; the bytes only ever see a copy.
	int unsigned sec_c  = 59;
	int unsigned min_c  = 59;
	int unsigned hour_c = 23;
	int unsigned day_c  = 3;
	int unsigned date_c = 28;
	int unsigned mon_c  = 2;
	int unsigned year_c = 24;
	logic        cent_c = 1'b0;
	function automatic logic [7:0] to_bcd(input int unsigned v);
		return {4'(v / 10), 4'(v % 10)};
	endfunction
	// The every-fourth-year leap rule is only good up to 2100.
	function automatic int unsigned month_len(input int unsigned m, input int unsigned y);
		if (m == 2) begin
			return (y % 4 == 0) ? 29 : 28;
		end
		if (m == 4 || m == 6 || m == 9 || m == 11) begin
			return 30;
		end
		return 31;
	endfunction
	// Counting carries on whatever the supply does; each tick refreshes the seven time bytes at once.
	always begin
		#(TICK_NS);
		sec_c = sec_c + 1;
		if (sec_c == 60) begin
			sec_c = 0;
			min_c = min_c + 1;
		end
		if (min_c == 60) begin
			min_c  = 0;
			hour_c = hour_c + 1;
		end
		if (hour_c == 24) begin
			hour_c = 0;
			day_c  = day_c % 7 + 1;
			date_c = date_c + 1;
		end
		if (date_c > month_len(mon_c, year_c)) begin
			date_c = 1;
			mon_c  = mon_c + 1;
		end
		if (mon_c == 13) begin
			mon_c  = 1;
			year_c = year_c + 1;
		end
		if (year_c == 100) begin
			year_c = 0;
			cent_c = !cent_c;
		end
		// The control byte is left alone; only the seven time bytes are rewritten.
		mem[CLOCK_BASE_LOC + 13'h1] = to_bcd(sec_c);
		mem[CLOCK_BASE_LOC + 13'h2] = to_bcd(min_c);
		mem[CLOCK_BASE_LOC + 13'h3] = to_bcd(hour_c);
		mem[CLOCK_BASE_LOC + 13'h4] = {3'h0, cent_c, 1'b0, 3'(day_c)};
		mem[CLOCK_BASE_LOC + 13'h5] = to_bcd(date_c);
		mem[CLOCK_BASE_LOC + 13'h6] = to_bcd(mon_c);
		mem[CLOCK_BASE_LOC + 13'h7] = to_bcd(year_c);
	end
endmodule

// File: verif/nvclk_host_tb.sv
`timescale 1ns/1ns
module nvclk_host_tb;
	import nvclk_host_pkg::*;
	logic        clk_sys = 0;
	logic        rst = 1;
	logic [1:0]  avs_address = 2'h0;
	logic        avs_read = 0;
	logic        avs_write = 0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [12:0] loc;
	logic        sna, sb, rdn, stn, uoe, doe;
	logic [7:0]  uout, dq, bus;
	logic        supply_good = 1;
	logic        below_backup = 0;
	logic [12:0] prev_loc;
	logic        prev_stn;
	logic [31:0] q;
	int          num_errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic [12:0] locs [5] = '{13'h0000, 13'h0aa5, 13'h1ff7, 13'h1ff8, 13'h1fff};
	always #2 clk_sys = ~clk_sys;
	// The host drives only when the device has let go; overlap is flagged below.
	assign bus = (uoe && !doe) ? uout : dq;
	nvclk_host uut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.location_lines(loc), .select_n_a(sna), .select_b(sb), .read_drive_n(rdn),
		.store_n(stn), .byte_pins_in(bus), .byte_pins_out(uout), .byte_pins_oe(uoe),
		.supply_good(supply_good), .below_backup(below_backup));
	nvclk_dev_model #(.TICK_NS(20000)) mdl (.location_lines(loc), .select_n_a(sna), .select_b(sb),
		.read_drive_n(rdn), .store_n(stn), .bus_in(bus), .dev_q(dq), .dev_oe(doe),
		.supply_good(supply_good), .below_backup(below_backup));
	task automatic results();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One Avalon transfer; the request stands until waitrequest is seen low at a rising edge.
	task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		if (n >= 100) num_errors++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Launch one pin cycle and poll busy; q holds the final status.
	task automatic op(input logic wr, input logic [12:0] l, input logic [7:0] d);
		int n;
		av(1'b1, REG_WDATA, {24'h0, d});
		av(1'b1, REG_CMD, {1'b1, 14'h0, wr, 3'h0, l});
		n = 0;
		do begin
			av(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 200);
	endtask
	// Wire-level watch: no contention, address steady while the strobe is low.
	always @(posedge clk_sys) begin
		prev_loc <= loc;
		prev_stn <= stn;
		if (!rst && uoe && doe) check("contention", 1, 0);
		if (!rst && !stn && !prev_stn && loc !== prev_loc) check("loc hold", 1, 0);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		// Back-to-back writes, then reads, across plain and clock bytes.
		foreach (locs[i]) begin
			op(1'b1, locs[i], locs[i][7:0] ^ 8'h5a);
			check("array", locs[i][7:0] ^ 8'h5a, mdl.mem[locs[i]]);
		end
		foreach (locs[i]) begin
			op(1'b0, locs[i], 8'h00);
			check("clock flag", locs[i] >= CLOCK_BASE_LOC, q[STAT_CLOCK_BIT]);
			av(1'b0, REG_RDATA, 32'h0);
			check("rdata", locs[i][7:0] ^ 8'h5a, q[7:0]);
			av(1'b0, REG_CMD, 32'h0);
			check("cmd loc", {19'h0, locs[i]}, q);
		end
		// Supply fault with battery: the go is refused and the byte survives.
		supply_good <= 1'b0;
		below_backup <= 1'b1;
		repeat (4) @(posedge clk_sys);
		op(1'b1, 13'h0000, 8'hff);
		check("status fail", 32'h16, q & 32'h1f);
		supply_good <= 1'b1;
		below_backup <= 1'b0;
		repeat (4) @(posedge clk_sys);
		op(1'b0, 13'h0000, 8'h00);
		check("status ok", 32'h00, q & 32'h1f);
		av(1'b0, REG_RDATA, 32'h0);
		check("kept", 8'h5a, q[7:0]);
		// The model's counters start one second before midnight of 28 February in a leap
		// year, so the single refresh inside the run must show the 29th at hour zero.
		repeat (5000) @(posedge clk_sys);
		op(1'b0, CLOCK_BASE_LOC + 13'h5, 8'h00);
		av(1'b0, REG_RDATA, 32'h0);
		check("date", 8'h29, q[7:0]);
		op(1'b0, CLOCK_BASE_LOC + 13'h3, 8'h00);
		av(1'b0, REG_RDATA, 32'h0);
		check("hours", 8'h00, q[7:0]);
		results();
	end
endmodule
